// ===== src/gpio_pin_config_bank.v
// Configuration bank and pin muxing for pins 2.1 through 3.1
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_pin_config_bank_defs.vh"

module gpio_pin_config_bank (
  input wire i_core_clk,
  input wire i_sys_rst,
  // Register port
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  output wire o_irq,
  // Pins, index 0..7 = 2.1 2.2 2.4 2.5 2.6 2.7 3.0 3.1
  input wire [7:0] i_pin_in,
  output wire [7:0] o_pin_out,
  output wire [7:0] o_pin_oe,
  // Alternate function sources
  input wire i_floppy_drive_select_1_n,
  input wire i_floppy_motor_select_1_n,
  input wire i_kbc_port_line_6,
  input wire i_kbc_port_line_2,
  input wire i_music_serial_transmit,
  input wire i_sys_mgmt_irq_n,
  // Alternate function sinks
  output reg o_kbc_port_line_6,
  output reg o_kbc_port_line_2,
  output reg o_music_serial_receive,
  output reg o_fan_speed_sense_1,
  output reg o_fan_speed_sense_2
);

  // ========================================================
  // Constant tables
  // All eight pins share one register layout; only the
  // alternate select differs: two bits on 2.1 and 2.2, none on 2.4.
  localparam NPIN = 8;

  // Offsets packed low pin first
  localparam [63:0] OFFS = {
    `OFF_PIN_3_1, `OFF_PIN_3_0, `OFF_PIN_2_7, `OFF_PIN_2_6,
    `OFF_PIN_2_5, `OFF_PIN_2_4, `OFF_PIN_2_2, `OFF_PIN_2_1
  };

  // Writable bits per pin, same packing
  localparam [63:0] MASKS = {
    `MASK_SINGLE, `MASK_SINGLE, `MASK_SINGLE, `MASK_SINGLE,
    `MASK_SINGLE, `MASK_NO_ALT, `MASK_DOUBLE, `MASK_DOUBLE
  };

  // ========================================================
  // Register storage
  reg [7:0] cfg_q [0:NPIN-1]; // Per pin configuration
  // The data register is split: writes set the output
  // levels, reads return the pins as the core sees them.
  reg [7:0] gpio_out_q; // Output data for plain pins
  reg [1:0] status_q; // Sticky edge flags
  reg [1:0] mask_q; // Interrupt enables
  reg [7:0] rdata_d; // Read mux result

  wire [NPIN-1:0] hit; // Config register address match
  wire [NPIN-1:0] pin_val; // Synced pin after polarity
  reg [NPIN-1:0] drive; // Wants to drive the pin
  reg [NPIN-1:0] data; // Logical level to drive

  wire hit_data; // Data register match
  wire hit_stat; // Status register match
  wire hit_mask; // Mask register match

  assign hit_data = (i_addr == `OFF_GPIO_DATA);
  assign hit_stat = (i_addr == `OFF_IRQ_STATUS);
  assign hit_mask = (i_addr == `OFF_IRQ_MASK);

  // ========================================================
  // Configuration registers, one per pin
  genvar k;
  generate
    for (k = 0; k < NPIN; k = k + 1) begin : g_cfg
      assign hit[k] = (i_addr == OFFS[k*8 +: 8]);

      // Reserved bits are dropped on the way in
      // Writes take effect at the strobe edge, no wait
      always @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          cfg_q[k] <= `RST_CONFIG;
        end else if (i_wr && hit[k]) begin
          cfg_q[k] <= i_wdata & MASKS[k*8 +: 8];
        end
      end

      // Pin driver cell
      gpio_pin_cell u_cell (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_pin_in(i_pin_in[k]),
        .i_drive(drive[k]),
        .i_data(data[k]),
        .i_pol(cfg_q[k][`BIT_POL]),
        .i_od(cfg_q[k][`BIT_OD]),
        .o_pin_out(o_pin_out[k]),
        .o_pin_oe(o_pin_oe[k]),
        .o_value(pin_val[k])
      );
    end
  endgenerate

  // ========================================================
  // Select fields
  wire [1:0] sel0; // Pin 2.1 two-bit select
  wire [1:0] sel1; // Pin 2.2 two-bit select
  wire [NPIN-1:0] alt; // Single-bit alternate enables
  wire [NPIN-1:0] dir_out; // Plain direction is output

  // Bits 3:2 only exist on pins 2.1 and 2.2; bit 2 of
  // pin 2.4 is masked on write, so alt[2] stays low.
  assign sel0 = cfg_q[0][`BIT_ALT_HI:`BIT_ALT];
  assign sel1 = cfg_q[1][`BIT_ALT_HI:`BIT_ALT];

  generate
    for (k = 0; k < NPIN; k = k + 1) begin : g_alt
      assign alt[k] = cfg_q[k][`BIT_ALT];
      assign dir_out[k] = ~cfg_q[k][`BIT_DIR];
    end
  endgenerate

  // ========================================================
  // Pin direction and data mux
  // Floppy, transmit and interrupt outputs drive regardless of
  // bit 0 and alternate inputs never drive, so a stale direction
  // cannot fight the far end of the wire there; keyboard mode
  // still drives only while bit 0 selects output.
  always @* begin
    drive = dir_out;
    data = gpio_out_q;
    // Pin 2.1
    case (sel0)
      `SEL_FLOPPY: begin
        drive[0] = 1'b1;
        data[0] = i_floppy_drive_select_1_n;
      end
      `SEL_EDGE: begin
        drive[0] = 1'b0;
      end
      `SEL_KBC: begin
        data[0] = i_kbc_port_line_6;
      end
      default: begin
        data[0] = gpio_out_q[0];
      end
    endcase
    // Pin 2.2
    case (sel1)
      `SEL_FLOPPY: begin
        drive[1] = 1'b1;
        data[1] = i_floppy_motor_select_1_n;
      end
      `SEL_EDGE: begin
        drive[1] = 1'b0;
      end
      `SEL_KBC: begin
        data[1] = i_kbc_port_line_2;
      end
      default: begin
        data[1] = gpio_out_q[1];
      end
    endcase
    // Pin 2.4 stays plain, bit 2 cannot be set
    drive[2] = dir_out[2];
    // Pin 2.5 becomes a receive input
    if (alt[3]) begin
      drive[3] = 1'b0;
    end
    // Pin 2.6 carries transmit data
    if (alt[4]) begin
      drive[4] = 1'b1;
      data[4] = i_music_serial_transmit;
    end
    // Pin 2.7 carries the management interrupt
    if (alt[5]) begin
      drive[5] = 1'b1;
      data[5] = i_sys_mgmt_irq_n;
    end
    // Fan sense pins are inputs only
    if (alt[6]) begin
      drive[6] = 1'b0;
    end
    if (alt[7]) begin
      drive[7] = 1'b0;
    end
  end

  // ========================================================
  // Alternate input routing
  // Idle levels are chosen so an unrouted sink looks quiet:
  // serial line high, fan sense low, keyboard lines high.
  // Registering the sinks costs one cycle but keeps
  // decode glitches away from the consumers.
  always @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_kbc_port_line_6 <= 1'b1;
      o_kbc_port_line_2 <= 1'b1;
      o_music_serial_receive <= 1'b1;
      o_fan_speed_sense_1 <= 1'b0;
      o_fan_speed_sense_2 <= 1'b0;
    end else begin
      // Keyboard lines read back the pin
      if (sel0 == `SEL_KBC) begin
        o_kbc_port_line_6 <= pin_val[0];
      end else begin
        o_kbc_port_line_6 <= 1'b1;
      end
      if (sel1 == `SEL_KBC) begin
        o_kbc_port_line_2 <= pin_val[1];
      end else begin
        o_kbc_port_line_2 <= 1'b1;
      end
      // Music receive
      if (alt[3]) begin
        o_music_serial_receive <= pin_val[3];
      end else begin
        o_music_serial_receive <= 1'b1;
      end
      // Fan sense 2 on pin 3.0
      if (alt[6]) begin
        o_fan_speed_sense_2 <= pin_val[6];
      end else begin
        o_fan_speed_sense_2 <= 1'b0;
      end
      // Fan sense 1 on pin 3.1
      if (alt[7]) begin
        o_fan_speed_sense_1 <= pin_val[7];
      end else begin
        o_fan_speed_sense_1 <= 1'b0;
      end
    end
  end

  // ========================================================
  // Either-edge detection
  // Only pins 2.1 and 2.2 offer the edge mode, so two
  // detectors cover every interrupt source of the bank.
  reg [1:0] prev_q; // Last seen level of pins 2.1, 2.2
  reg [1:0] edge_arm_q; // Edge mode held last cycle
  wire [1:0] edge_mode; // Edge mode selected now
  wire [1:0] edge_evt; // One-cycle edge events

  assign edge_mode[0] = (sel0 == `SEL_EDGE);
  assign edge_mode[1] = (sel1 == `SEL_EDGE);

  // Arming one cycle late stops a mode switch from
  // comparing against a level taken in another mode.
  assign edge_evt = edge_mode & edge_arm_q &
                    (pin_val[1:0] ^ prev_q);

  // Previous level and arm tracking
  always @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      prev_q <= 2'h0;
      edge_arm_q <= 2'h0;
    end else begin
      prev_q <= pin_val[1:0];
      edge_arm_q <= edge_mode;
    end
  end

  // ========================================================
  // Sticky status, write one to clear
  // A new edge in the clearing cycle survives the clear.
  // Bits 7:2 do not exist and always read zero.
  always @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      status_q <= 2'h0;
    end else if (i_wr && hit_stat) begin
      status_q <= (status_q & ~i_wdata[1:0]) | edge_evt;
    end else begin
      status_q <= status_q | edge_evt;
    end
  end

  // ========================================================
  // Mask and output data registers
  // Only bits 1:0 of the mask exist, one per edge pin
  always @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mask_q <= 2'h0;
      gpio_out_q <= `RST_ZERO;
    end else if (i_wr) begin
      if (hit_mask) begin
        mask_q <= i_wdata[1:0];
      end
      if (hit_data) begin
        gpio_out_q <= i_wdata;
      end
    end
  end

  // Level interrupt from any unmasked flag
  // Combinational, so a mask write acts at once
  assign o_irq = |(status_q & mask_q);

  // ========================================================
  // Read mux
  integer j;
  always @* begin
    rdata_d = 8'h00;
    // Reserved slot and unmapped reads fall through as zero
    // Later tests override earlier ones; the address
    // ranges never overlap, so the order is only for reading.
    for (j = 0; j < NPIN; j = j + 1) begin
      if (i_addr == OFFS[j*8 +: 8]) begin
        rdata_d = cfg_q[j];
      end
    end
    if (i_addr == `OFF_RSVD_2E) begin
      rdata_d = 8'h00;
    end
    if (hit_data) begin
      rdata_d = pin_val;
    end
    if (hit_stat) begin
      rdata_d = {6'h00, status_q};
    end
    if (hit_mask) begin
      rdata_d = {6'h00, mask_q};
    end
  end

  // Read data valid only the cycle after the strobe
  // Zero between reads, so a stale byte is never taken
  // for a fresh answer.
  always @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= rdata_d;
    end else begin
      o_rdata <= 8'h00;
    end
  end

endmodule

`default_nettype wire

// ===== src/gpio_pin_config_bank_defs.vh
// Constants for the pin configuration bank of pins 2.1 to 3.1
//
// Summary of operation
// - Bit 0 one means input, zero output
// - Bit 1 one inverts pin value
// - Bit 7 one open-drain, zero push-pull
// - Bit 2 one routes pin to alternate
// - Pin 2.1 select: drive, edge, kbc, gpio
// - Pin 2.2 select: motor, edge, kbc, gpio
// - Offset 2E reserved, reads zero
// - Pin 2.4 has no alternate function
// - Pin 2.5 alternate feeds music receive
// - Pin 2.6 alternate driven by music transmit
// - Pin 2.7 alternate carries management interrupt
// - Pin 3.0 alternate feeds fan sense 2
// - Pin 3.1 alternate feeds fan sense 1
`ifndef GPIO_PIN_CONFIG_BANK_DEFS_VH
`define GPIO_PIN_CONFIG_BANK_DEFS_VH

// ==========================================================
// Register offsets
`define OFF_PIN_2_1 8'h2C
`define OFF_PIN_2_2 8'h2D
`define OFF_RSVD_2E 8'h2E
`define OFF_PIN_2_4 8'h2F
`define OFF_PIN_2_5 8'h30
`define OFF_PIN_2_6 8'h31
`define OFF_PIN_2_7 8'h32
`define OFF_PIN_3_0 8'h33
`define OFF_PIN_3_1 8'h34
`define OFF_GPIO_DATA 8'h40
`define OFF_IRQ_STATUS 8'h41
`define OFF_IRQ_MASK 8'h42

// ==========================================================
// Field positions
`define BIT_DIR 0
`define BIT_POL 1
`define BIT_ALT 2
`define BIT_ALT_HI 3
`define BIT_OD 7

// ==========================================================
// Writable bit masks and reset values
`define MASK_SINGLE 8'h87
`define MASK_DOUBLE 8'h8F
`define MASK_NO_ALT 8'h83
`define RST_CONFIG 8'h01
`define RST_ZERO 8'h00

// ==========================================================
// Two-bit alternate select codes
`define SEL_FLOPPY 2'h3
`define SEL_EDGE 2'h2
`define SEL_KBC 2'h1
`define SEL_GPIO 2'h0

`endif

// ===== src/gpio_pin_cell.v
// One configurable pin: input synchroniser, polarity and driver type
`timescale 1ns/1ps
`default_nettype none

module gpio_pin_cell (
  input wire i_core_clk,
  input wire i_sys_rst,
  input wire i_pin_in,
  input wire i_drive,
  input wire i_data,
  input wire i_pol,
  input wire i_od,
  output reg o_pin_out,
  output reg o_pin_oe,
  output wire o_value
);

  // ========================================================
  // Input synchroniser
  reg sync1_q; // First stage, read only by second
  reg sync2_q; // Stable pin level

  // Two flops since the pin is asynchronous
  always @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= i_pin_in;
      sync2_q <= sync1_q;
    end
  end

  // Inversion sits between logic and pin
  assign o_value = sync2_q ^ i_pol;

  // ========================================================
  // Output driver
  wire level; // Level to put on the pin
  assign level = i_data ^ i_pol;

  // Registered so the pin never glitches on decode
  always @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pin_out <= 1'b0;
      o_pin_oe <= 1'b0;
    end else if (i_od) begin
      // Open drain only ever pulls low
      o_pin_out <= 1'b0;
      o_pin_oe <= i_drive & ~level;
    end else begin
      // Push-pull drives both levels
      o_pin_out <= level;
      o_pin_oe <= i_drive;
    end
  end

endmodule

`default_nettype wire

// ===== bench/pin_board.sv
// Board model of the pin wires, with pull-ups and an outside driver
`timescale 1ns/1ps
`default_nettype none
module pin_board (
  input wire logic [7:0] i_out,
  input wire logic [7:0] i_oe,
  input wire logic [7:0] i_ext_val,
  input wire logic [7:0] i_ext_en,
  output logic [7:0] o_level
);
  // ==========================================
  // Wire resolution
  // Pins released by both sides go to the pull-up level, never keep an old value
  assign o_level = (i_oe & i_out) | (~i_oe & ~i_ext_en) |
    (~i_oe & i_ext_en & i_ext_val);
endmodule
`default_nettype wire

// ===== bench/gpio_pin_config_bank_chk.sv
// Assertion checker for the pin configuration bank
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_config_bank_chk (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic o_irq,
  input wire logic [7:0] o_pin_out,
  input wire logic [7:0] o_pin_oe,
  input wire logic i_floppy_drive_select_1_n,
  input wire logic o_kbc_port_line_6
);
  // All properties run on the core clock, quiet in reset
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);
  // ==========================================
  // Shadow of pin 2.1 setup, so pin outputs can be tied to it
  logic [7:0] cfg_q; // Pin 2.1 configuration
  logic dat_q; // Output data bit of pin 2.1
  logic alt_q; // Expected drive select level
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cfg_q <= 8'h01;
      dat_q <= 1'b0;
      alt_q <= 1'b0;
    end else begin
      if (i_wr && i_addr == 8'h2C) begin
        cfg_q <= i_wdata & 8'h8F;
      end
      if (i_wr && i_addr == 8'h40) begin
        dat_q <= i_wdata[0];
      end
      alt_q <= i_floppy_drive_select_1_n ^ cfg_q[1];
    end
  end
  // ==========================================
  // Properties
  a_rsvd_slot_zero: assert property ($past(i_rd) &&
    $past(i_addr) == 8'h2E |-> o_rdata == 8'h00) else $error("slot");
  a_rsvd_bits_low: assert property ($past(i_rd) &&
    $past(i_addr) inside {8'h2C, 8'h2D} |-> o_rdata[6:4] == 3'h0)
    else $error("reserved bits");
  a_no_alt_bit: assert property ($past(i_rd) &&
    $past(i_addr) == 8'h2F |-> o_rdata[6:2] == 5'h00) else $error("2.4");
  a_single_select: assert property ($past(i_rd) &&
    $past(i_addr) inside {[8'h30:8'h34]} |-> o_rdata[6:3] == 4'h0)
    else $error("single select");
  a_input_released: assert property (cfg_q[3:0] == 4'h1
    |=> o_pin_oe[0] == 1'b0) else $error("input drives");
  a_push_pull: assert property (cfg_q[3:2] == 2'h0 &&
    cfg_q[7] == 1'b0 && cfg_q[0] == 1'b0 |=> o_pin_oe[0] &&
    o_pin_out[0] == ($past(dat_q) ^ $past(cfg_q[1]))) else $error("pp");
  a_open_drain: assert property (cfg_q[3:2] == 2'h0 &&
    cfg_q[7] && cfg_q[0] == 1'b0 |=> o_pin_out[0] == 1'b0 &&
    o_pin_oe[0] == !($past(dat_q) ^ $past(cfg_q[1]))) else $error("od");
  a_drive_select: assert property (cfg_q[3:2] == 2'h3 &&
    cfg_q[7] == 1'b0 |=> o_pin_oe[0] && o_pin_out[0] == alt_q)
    else $error("drive select");
  a_kbc_idle_high: assert property (cfg_q[3:2] != 2'h1
    |=> o_kbc_port_line_6) else $error("kbc idle");
  a_irq_sticky: assert property (o_irq && !(i_wr &&
    i_addr inside {8'h41, 8'h42}) |=> o_irq) else $error("irq lost");
  c_irq: cover property (o_irq);
  c_drive: cover property (cfg_q[3:2] == 2'h3);
  c_slot: cover property ($past(i_rd) && $past(i_addr) == 8'h2E);
endmodule
bind gpio_pin_config_bank gpio_pin_config_bank_chk u_chk (
  .i_core_clk(i_core_clk),
  .i_sys_rst(i_sys_rst),
  .i_addr(i_addr),
  .i_wdata(i_wdata),
  .i_wr(i_wr),
  .i_rd(i_rd),
  .o_rdata(o_rdata),
  .o_irq(o_irq),
  .o_pin_out(o_pin_out),
  .o_pin_oe(o_pin_oe),
  .i_floppy_drive_select_1_n(i_floppy_drive_select_1_n),
  .o_kbc_port_line_6(o_kbc_port_line_6)
);
`default_nettype wire

// ===== bench/gpio_pin_config_bank_test.sv
// Self-checking testbench for the pin configuration bank
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_config_bank_test;
  // ==========================================
  // Stimulus and observed signals
  logic clk = 1'b0; // Core clock
  logic rst = 1'b1; // Active high reset
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [5:0] src = 6'h3F; // Alternate sources, idle high
  logic [7:0] ext_val = 8'h00; // Level the board forces
  logic [7:0] ext_en = 8'h00; // Board drives the pin
  logic [7:0] rdata, pin_out, pin_oe, lvl;
  logic irq, kbc6, kbc2, rx, fan1, fan2;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  gpio_pin_config_bank dut (.i_core_clk(clk), .i_sys_rst(rst),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .o_irq(irq), .i_pin_in(lvl),
    .o_pin_out(pin_out), .o_pin_oe(pin_oe),
    .i_floppy_drive_select_1_n(src[0]),
    .i_floppy_motor_select_1_n(src[1]), .i_kbc_port_line_6(src[2]),
    .i_kbc_port_line_2(src[3]), .i_music_serial_transmit(src[4]),
    .i_sys_mgmt_irq_n(src[5]), .o_kbc_port_line_6(kbc6),
    .o_kbc_port_line_2(kbc2), .o_music_serial_receive(rx),
    .o_fan_speed_sense_1(fan1), .o_fan_speed_sense_2(fan2));
  pin_board board (.i_out(pin_out), .i_oe(pin_oe), .i_ext_val(ext_val),
    .i_ext_en(ext_en), .o_level(lvl));
  // ==========================================
  // Shared tasks
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Hang guard, well above the run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic chk(input string n, input logic [7:0] e,
    input logic [7:0] s);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, m, e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("read", e, rdata & m);
  endtask
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic restore();
    for (int a = 8'h2C; a <= 8'h34; a++) begin
      wr_reg(a[7:0], 8'h01);
    end
  endtask
  function automatic logic [7:0] p0();
    p0 = {6'h0, pin_oe[0], pin_out[0]};
  endfunction
  // ==========================================
  // Scenarios
  task automatic t_reset_vals();
    chk("sinks", 8'h1C, {3'h0, kbc6, kbc2, rx, fan1, fan2});
    chk("oe", 8'h00, pin_oe);
    for (int a = 8'h2C; a <= 8'h34; a++) begin
      rd_reg(a[7:0], 8'hFF, (a == 8'h2E) ? 8'h00 : 8'h01);
    end
    rd_reg(8'h50, 8'hFF, 8'h00);
  endtask
  // Reserved bits drop, select width differs per pin
  task automatic t_masks();
    logic [7:0] m;
    for (int a = 8'h2C; a <= 8'h34; a++) begin
      m = (a < 8'h2E) ? 8'h8F : (a == 8'h2E) ? 8'h00 : 8'h87;
      m = (a == 8'h2F) ? 8'h83 : m;
      wr_reg(a[7:0], 8'hFF);
      rd_reg(a[7:0], 8'hFF, m);
    end
    restore();
  endtask
  task automatic t_pins();
    wr_reg(8'h40, 8'h01);
    wr_reg(8'h2C, 8'h00);
    settle();
    chk("pp", 8'h03, p0());
    wr_reg(8'h2C, 8'h02);
    settle();
    chk("inv", 8'h02, p0());
    wr_reg(8'h2C, 8'h80);
    settle();
    chk("od_off", 8'h00, p0());
    wr_reg(8'h40, 8'h00);
    settle();
    chk("od_low", 8'h02, p0());
    wr_reg(8'h2C, 8'h03);
    ext_en <= 8'h01;
    settle();
    rd_reg(8'h40, 8'h01, 8'h01);
    wr_reg(8'h2C, 8'h01);
    settle();
    rd_reg(8'h40, 8'h01, 8'h00);
    @(posedge clk);
    ext_en <= 8'h00;
  endtask
  // Data register holds zero, so only the sources can raise pins
  task automatic t_alt_out();
    wr_reg(8'h2C, 8'h0D);
    wr_reg(8'h2D, 8'h0C);
    wr_reg(8'h31, 8'h05);
    wr_reg(8'h32, 8'h04);
    src <= 6'h00;
    settle();
    chk("alt_oe", 8'h33, pin_oe & 8'h33);
    chk("alt_lo", 8'h00, pin_out & 8'h33);
    @(posedge clk);
    src <= 6'h3F;
    settle();
    chk("alt_hi", 8'h33, pin_out & 8'h33);
    // Keyboard mode as output: pins follow the controller lines
    wr_reg(8'h2C, 8'h04);
    wr_reg(8'h2D, 8'h04);
    src <= 6'h04;
    settle();
    chk("kbc_oe", 8'h03, pin_oe & 8'h03);
    chk("kbc_out", 8'h01, pin_out & 8'h03);
    @(posedge clk);
    src <= 6'h3F;
    restore();
  endtask
  // Two level patterns catch swaps with the kbc2 or fan2 sink; kbc6, rx and fan1 share one pattern
  task automatic t_alt_in();
    wr_reg(8'h2C, 8'h05);
    wr_reg(8'h2D, 8'h05);
    wr_reg(8'h30, 8'h05);
    wr_reg(8'h33, 8'h05);
    wr_reg(8'h34, 8'h05);
    ext_en <= 8'hFF;
    ext_val <= 8'h40;
    settle();
    chk("in_a", 8'h01, {3'h0, kbc6, kbc2, rx, fan1, fan2});
    @(posedge clk);
    ext_val <= 8'h89;
    settle();
    chk("in_b", 8'h16, {3'h0, kbc6, kbc2, rx, fan1, fan2});
    @(posedge clk);
    ext_en <= 8'h00;
    restore();
  endtask
  task automatic t_irq();
    ext_en <= 8'h01;
    ext_val <= 8'h01;
    wr_reg(8'h2C, 8'h09);
    wr_reg(8'h42, 8'h03);
    ext_val <= 8'h00;
    settle();
    rd_reg(8'h41, 8'h03, 8'h01);
    chk("irq", 8'h01, {7'h0, irq});
    wr_reg(8'h41, 8'h01);
    ext_val <= 8'h01;
    #1;
    chk("irq_clr", 8'h00, {7'h0, irq});
    settle();
    rd_reg(8'h41, 8'h03, 8'h01);
    wr_reg(8'h42, 8'h00);
    #1;
    chk("irq_mask", 8'h00, {7'h0, irq});
    wr_reg(8'h41, 8'h03);
    wr_reg(8'h2C, 8'h01);
    ext_val <= 8'h00;
    settle();
    rd_reg(8'h41, 8'h03, 8'h00);
  endtask
  // Pin 2.2 edge lands in status bit 1 only
  task automatic t_irq_b();
    @(posedge clk);
    ext_en <= 8'h02;
    ext_val <= 8'h00;
    wr_reg(8'h2D, 8'h09);
    wr_reg(8'h42, 8'h02);
    ext_val <= 8'h02;
    settle();
    rd_reg(8'h41, 8'h03, 8'h02);
    chk("irq_b", 8'h01, {7'h0, irq});
    wr_reg(8'h41, 8'h02);
    wr_reg(8'h2D, 8'h01);
    wr_reg(8'h42, 8'h00);
    rd_reg(8'h41, 8'h03, 8'h00);
    @(posedge clk);
    ext_en <= 8'h00;
  endtask
  // Reset in mid-run brings back every default
  task automatic t_mid_reset();
    wr_reg(8'h2C, 8'h8F);
    wr_reg(8'h42, 8'h03);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("rst_oe", 8'h00, pin_oe);
    rd_reg(8'h2C, 8'hFF, 8'h01);
    rd_reg(8'h42, 8'hFF, 8'h00);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset_vals();
    t_masks();
    t_pins();
    t_alt_out();
    t_alt_in();
    t_irq();
    t_irq_b();
    t_mid_reset();
    report_and_stop();
  end
endmodule
`default_nettype wire
